// ==== hw/bmf_pkg.sv ====
// constants, types and decoding helpers of the bus-matching fifo control
// assumes one 10 mhz clock and that every pin input is synchronised first

package bmf_pkg;

    // ---------------------------------------------------------------
    // sizes
    // ---------------------------------------------------------------
    localparam int DATA_W = 36;
    localparam int DEPTH = 256;
    localparam int ADDR_W = 8;
    localparam int OFS_W = 8;
    localparam logic [4:0] SER_BITS = 5'h10;

    // ---------------------------------------------------------------
    // preset offsets and reset values
    // ---------------------------------------------------------------
    localparam logic [OFS_W-1:0] OFS_PRESET_8 = 8'h08;
    localparam logic [OFS_W-1:0] OFS_PRESET_16 = 8'h10;
    localparam logic [OFS_W-1:0] OFS_PRESET_64 = 8'h40;
    localparam logic [OFS_W-1:0] OFS_RST = 8'h40;
    localparam logic MB_FLAG_RST = 1'b1;
    localparam logic BIG_RST = 1'b0;

    // ---------------------------------------------------------------
    // register map, word index on the avalon slave
    // ---------------------------------------------------------------
    localparam logic [1:0] REG_STATUS = 2'h0;
    localparam logic [1:0] REG_OFFSETS = 2'h1;
    localparam logic [1:0] REG_CONTROL = 2'h2;
    localparam int ST_FULL_FLAG = 0;
    localparam int ST_EMPTY_FLAG = 1;
    localparam int ST_MAILBOX_ONE_FLAG = 2;
    localparam int ST_MAILBOX_TWO_FLAG = 3;
    localparam int ST_WIDTH = 4;
    localparam int ST_BIG = 6;
    localparam int ST_FWFT = 7;
    localparam int ST_PROG = 8;
    localparam int ST_FILL = 12;
    localparam int OF_X = 0;
    localparam int OF_Y = 16;
    localparam int CT_FLUSH = 0;

    // ---------------------------------------------------------------
    // types
    // ---------------------------------------------------------------
    typedef enum logic [1:0] {
        BMF_W36 = 2'h0,
        BMF_W18 = 2'h1,
        BMF_W9 = 2'h2
    } bmf_width_t;

    typedef enum logic [1:0] {
        PRG_RESET = 2'h0,
        PRG_SERIAL = 2'h1,
        PRG_PARALLEL = 2'h3,
        PRG_DONE = 2'h2
    } bmf_prog_t;

    // ---------------------------------------------------------------
    // port b width helpers
    // ---------------------------------------------------------------
    function automatic logic [DATA_W-1:0] bmf_mask(
        input logic [DATA_W-1:0] w,
        input bmf_width_t ws
    );
        logic [DATA_W-1:0] r;
        case (ws)
            BMF_W18: r = {18'h0, w[17:0]};
            BMF_W9: r = {27'h0, w[8:0]};
            default: r = w;
        endcase
        return r;
    endfunction

    function automatic logic [DATA_W-1:0] bmf_piece(
        input logic [DATA_W-1:0] w,
        input bmf_width_t ws,
        input logic [1:0] idx,
        input logic big
    );
        logic [1:0] pos;
        logic [DATA_W-1:0] r;
        pos = big ? (2'h3 - idx) : idx;
        case (ws)
            BMF_W18: r = ((big ^ idx[0]) ? {18'h0, w[35:18]}
                                         : {18'h0, w[17:0]});
            BMF_W9: begin
                case (pos)
                    2'h0: r = {27'h0, w[8:0]};
                    2'h1: r = {27'h0, w[17:9]};
                    2'h2: r = {27'h0, w[26:18]};
                    default: r = {27'h0, w[35:27]};
                endcase
            end
            default: r = w;
        endcase
        return r;
    endfunction

    function automatic logic bmf_last(
        input bmf_width_t ws,
        input logic [1:0] idx
    );
        logic r;
        case (ws)
            BMF_W18: r = idx[0];
            BMF_W9: r = (idx == 2'h3);
            default: r = 1'b1;
        endcase
        return r;
    endfunction

endpackage

// ==== hw/bmf_sync.sv ====
// two-flop synchroniser for a group of pin inputs
// assumes the pins change slowly against the system clock
`timescale 1ns/10ps

module bmf_sync #(
    parameter int W = 1
) (
    // clock and reset
    input wire logic clk_in,
    input wire logic rst_n_in,
    // pins and their synchronised copy
    input wire logic [W-1:0] d_in,
    output logic [W-1:0] q_out
);

    logic [W-1:0] meta_r;
    logic [W-1:0] q_r;

    always_ff @(posedge clk_in or negedge rst_n_in) begin
        if (!rst_n_in) begin
            meta_r <= '0;
            q_r <= '0;
        end else begin
            meta_r <= d_in;
            q_r <= meta_r;
        end
    end

    assign q_out = q_r;

endmodule

// ==== hw/bmf_port_ctrl.sv ====
// port control of the bus-matching fifo: pins, mailboxes, resets, offsets
// assumes port clocks run at most a quarter of clk_in; all pins synchronised
//
// Our own choices: the register addresses and the Avalon-MM interface to the registers.
`timescale 1ns/10ps

module bmf_port_ctrl
    import bmf_pkg::*;
(
    // clock and reset
    input wire logic clk_in,
    input wire logic rst_n_in,
    // port a pins
    input wire logic port_a_clock_in,
    input wire logic port_a_enable_in,
    input wire logic port_a_chip_select_n_in,
    input wire logic port_a_write_read_select_in,
    input wire logic port_a_mailbox_select_in,
    input wire logic [DATA_W-1:0] a_data_in,
    output logic [DATA_W-1:0] a_data_out,
    output logic a_data_oe_out,
    output logic full_or_input_ready_flag_out,
    output logic mailbox_two_flag_out,
    // port b pins
    input wire logic port_b_clock_in,
    input wire logic port_b_enable_in,
    input wire logic port_b_chip_select_n_in,
    input wire logic port_b_write_read_select_in,
    input wire logic port_b_mailbox_select_in,
    input wire logic [DATA_W-1:0] b_data_in,
    output logic [DATA_W-1:0] b_data_out,
    output logic b_data_oe_out,
    output logic empty_or_output_ready_flag_out,
    output logic mailbox_one_flag_out,
    // reset and configuration pins
    input wire logic full_reset_one_in,
    input wire logic full_reset_two_in,
    input wire logic partial_reset_n_in,
    input wire logic serial_program_mode_n_in,
    input wire logic bus_match_select_in,
    input wire logic size_select_in,
    input wire logic byte_order_timing_select_in,
    input wire logic offset_select1_serial_enable_in,
    input wire logic offset_select0_serial_data_in,
    // avalon-mm slave
    input wire logic [1:0] avs_address_in,
    input wire logic avs_read_in,
    input wire logic avs_write_in,
    input wire logic [31:0] avs_writedata_in,
    input wire logic [3:0] avs_byteenable_in,
    output logic [31:0] avs_readdata_out,
    output logic avs_waitrequest_out
);

    // ---------------------------------------------------------------
    // pin synchronisation
    // ---------------------------------------------------------------
    localparam int SYNC_W = 19 + 2 * DATA_W;

    logic [SYNC_W-1:0] sync_q;
    logic a_clk_q, ena_q, csa_n_q, wra_q, mba_q;
    logic b_clk_q, enb_q, csb_n_q, wrb_q, mbb_q;
    logic rs1_q, rs2_q, prs_n_q, spm_n_q, bm_q, size_q, be_q, fs1_q, fs0_q;
    logic [DATA_W-1:0] a_d_q;
    logic [DATA_W-1:0] b_d_q;

    bmf_sync #(
        .W(SYNC_W)
    ) u_sync (
        .clk_in(clk_in),
        .rst_n_in(rst_n_in),
        .d_in({port_a_clock_in, port_a_enable_in, port_a_chip_select_n_in,
               port_a_write_read_select_in, port_a_mailbox_select_in,
               port_b_clock_in, port_b_enable_in, port_b_chip_select_n_in,
               port_b_write_read_select_in, port_b_mailbox_select_in,
               full_reset_one_in, full_reset_two_in, partial_reset_n_in,
               serial_program_mode_n_in, bus_match_select_in,
               size_select_in, byte_order_timing_select_in,
               offset_select1_serial_enable_in,
               offset_select0_serial_data_in, a_data_in, b_data_in}),
        .q_out(sync_q)
    );

    assign {a_clk_q, ena_q, csa_n_q, wra_q, mba_q,
            b_clk_q, enb_q, csb_n_q, wrb_q, mbb_q,
            rs1_q, rs2_q, prs_n_q, spm_n_q, bm_q, size_q, be_q,
            fs1_q, fs0_q, a_d_q, b_d_q} = sync_q;

    // ---------------------------------------------------------------
    // edge detection
    // ---------------------------------------------------------------
    logic a_clk_d_r;
    logic b_clk_d_r;
    logic rs1_d_r;

    always_ff @(posedge clk_in or negedge rst_n_in) begin
        if (!rst_n_in) begin
            a_clk_d_r <= 1'b0;
            b_clk_d_r <= 1'b0;
            rs1_d_r <= 1'b0;
        end else begin
            a_clk_d_r <= a_clk_q;
            b_clk_d_r <= b_clk_q;
            rs1_d_r <= rs1_q;
        end
    end

    // ---------------------------------------------------------------
    // state declarations
    // ---------------------------------------------------------------
    logic [DATA_W-1:0] mem_r [DEPTH];
    logic [ADDR_W:0] wptr_r;
    logic [ADDR_W:0] rptr_r;
    logic [1:0] idx_r;
    logic [DATA_W-1:0] b_out_r;
    logic [DATA_W-1:0] mail1_r;
    logic [DATA_W-1:0] mail2_r;
    logic mailbox_one_flag_r;
    logic mailbox_two_flag_r;
    bmf_width_t width_r;
    logic big_r;
    bmf_prog_t prg_r;
    bmf_prog_t prg_nxt;
    logic [OFS_W-1:0] ofs_x_r;
    logic [OFS_W-1:0] ofs_y_r;
    logic [4:0] ser_cnt_r;
    logic ack_r;
    logic flush_r;
    logic [31:0] rdata_r;

    // ---------------------------------------------------------------
    // port qualification
    // ---------------------------------------------------------------
    logic a_edge, b_edge, a_act, b_act, a_wr, a_rd, b_wr, b_rd;
    logic rs1_rise, full_rst, ptr_rst, fwft;

    assign a_edge = a_clk_q & ~a_clk_d_r;
    assign b_edge = b_clk_q & ~b_clk_d_r;
    assign a_act = a_edge & ena_q & ~csa_n_q;
    assign b_act = b_edge & enb_q & ~csb_n_q;
    assign a_wr = a_act & wra_q;
    assign a_rd = a_act & ~wra_q;
    assign b_wr = b_act & ~wrb_q;
    assign b_rd = b_act & wrb_q;
    assign rs1_rise = rs1_q & ~rs1_d_r;
    assign full_rst = ~rs1_q & ~rs2_q;
    assign ptr_rst = full_rst | ~prs_n_q | flush_r;
    assign fwft = ~be_q;

    // ---------------------------------------------------------------
    // fifo status and data path
    // ---------------------------------------------------------------
    logic [ADDR_W:0] fill;
    logic full, empty, prog_done, rd_last, fifo_wr, fifo_rd;
    logic [DATA_W-1:0] piece_cur;

    assign fill = wptr_r - rptr_r;
    assign full = (fill == DEPTH[ADDR_W:0]);
    assign empty = (fill == '0);
    assign prog_done = (prg_r == PRG_DONE);
    assign piece_cur = bmf_piece(mem_r[rptr_r[ADDR_W-1:0]], width_r,
                                 idx_r, big_r);
    assign rd_last = bmf_last(width_r, idx_r);
    assign fifo_wr = a_wr & ~mba_q & prog_done & ~full & ~ptr_rst;
    assign fifo_rd = b_rd & ~mbb_q & ~empty & ~ptr_rst;

    always_ff @(posedge clk_in) begin
        if (fifo_wr) begin
            mem_r[wptr_r[ADDR_W-1:0]] <= a_d_q;
        end
    end

    always_ff @(posedge clk_in or negedge rst_n_in) begin
        if (!rst_n_in) begin
            wptr_r <= '0;
            rptr_r <= '0;
            idx_r <= 2'h0;
        end else if (ptr_rst) begin
            wptr_r <= '0;
            rptr_r <= '0;
            idx_r <= 2'h0;
        end else begin
            if (fifo_wr) begin
                wptr_r <= wptr_r + 1'b1;
            end
            if (fifo_rd) begin
                rptr_r <= rd_last ? rptr_r + 1'b1 : rptr_r;
                idx_r <= rd_last ? 2'h0 : idx_r + 2'h1;
            end
        end
    end

    // output register: loaded on read, or kept primed in fall-through mode
    always_ff @(posedge clk_in or negedge rst_n_in) begin
        if (!rst_n_in) begin
            b_out_r <= '0;
        end else if (ptr_rst) begin
            b_out_r <= '0;
        end else if (fwft ? ~empty : fifo_rd) begin
            b_out_r <= piece_cur;
        end
    end

    // ---------------------------------------------------------------
    // mailboxes
    // ---------------------------------------------------------------
    logic mb1_wr, mb1_rd, mb2_wr, mb2_rd;

    assign mb1_wr = a_wr & mba_q & mailbox_one_flag_r;
    assign mb1_rd = b_rd & mbb_q;
    assign mb2_wr = b_wr & mbb_q & mailbox_two_flag_r;
    assign mb2_rd = a_rd & mba_q;

    always_ff @(posedge clk_in or negedge rst_n_in) begin
        if (!rst_n_in) begin
            mail1_r <= '0;
            mail2_r <= '0;
        end else begin
            if (mb1_wr) begin
                mail1_r <= bmf_mask(a_d_q, width_r);
            end
            if (mb2_wr) begin
                mail2_r <= bmf_mask(b_d_q, width_r);
            end
        end
    end

    // a new write wins over a read in the same cycle
    always_ff @(posedge clk_in or negedge rst_n_in) begin
        if (!rst_n_in) begin
            mailbox_one_flag_r <= MB_FLAG_RST;
            mailbox_two_flag_r <= MB_FLAG_RST;
        end else begin
            if (~rs1_q | ~prs_n_q | flush_r) begin
                mailbox_one_flag_r <= 1'b1;
            end else if (mb1_wr) begin
                mailbox_one_flag_r <= 1'b0;
            end else if (mb1_rd) begin
                mailbox_one_flag_r <= 1'b1;
            end
            if (~rs2_q | ~prs_n_q | flush_r) begin
                mailbox_two_flag_r <= 1'b1;
            end else if (mb2_wr) begin
                mailbox_two_flag_r <= 1'b0;
            end else if (mb2_rd) begin
                mailbox_two_flag_r <= 1'b1;
            end
        end
    end

    // ---------------------------------------------------------------
    // configuration latched at every rising edge of full reset one
    // ---------------------------------------------------------------
    always_ff @(posedge clk_in or negedge rst_n_in) begin
        if (!rst_n_in) begin
            width_r <= BMF_W36;
            big_r <= BIG_RST;
        end else if (rs1_rise) begin
            width_r <= ~bm_q ? BMF_W36
                     : (size_q ? BMF_W9 : BMF_W18);
            big_r <= be_q;
        end
    end

    // ---------------------------------------------------------------
    // offset programming
    // ---------------------------------------------------------------
    logic ser_shift;
    logic par_load;
    logic [OFS_W-1:0] preset;

    assign ser_shift = (prg_r == PRG_SERIAL) & a_edge & ~fs1_q;
    assign par_load = (prg_r == PRG_PARALLEL) & a_wr & ~mba_q;
    assign preset = fs0_q ? OFS_PRESET_16 : (fs1_q ? OFS_PRESET_8
                                                   : OFS_PRESET_64);

    always_comb begin
        prg_nxt = prg_r;
        case (prg_r)
            PRG_RESET: begin
                if (rs1_rise) begin
                    prg_nxt = ~spm_n_q ? PRG_SERIAL
                            : ((fs1_q & fs0_q) ? PRG_PARALLEL : PRG_DONE);
                end
            end
            PRG_SERIAL: begin
                if (ser_shift & (ser_cnt_r == SER_BITS - 5'h1)) begin
                    prg_nxt = PRG_DONE;
                end
            end
            PRG_PARALLEL: begin
                if (par_load) begin
                    prg_nxt = PRG_DONE;
                end
            end
            PRG_DONE: prg_nxt = PRG_DONE;
            default: prg_nxt = PRG_RESET;
        endcase
        if (~rs1_q) begin
            prg_nxt = PRG_RESET;
        end
    end

    always_ff @(posedge clk_in or negedge rst_n_in) begin
        if (!rst_n_in) begin
            prg_r <= PRG_RESET;
        end else begin
            prg_r <= prg_nxt;
        end
    end

    // partial reset never touches the offsets
    always_ff @(posedge clk_in or negedge rst_n_in) begin
        if (!rst_n_in) begin
            ofs_x_r <= OFS_RST;
            ofs_y_r <= OFS_RST;
            ser_cnt_r <= 5'h0;
        end else if (prg_r == PRG_RESET) begin
            ser_cnt_r <= 5'h0;
            if (rs1_rise & ~spm_n_q) begin
                ofs_x_r <= ofs_x_r;
            end else if (rs1_rise & ~(fs1_q & fs0_q)) begin
                ofs_x_r <= preset;
                ofs_y_r <= preset;
            end
        end else if (ser_shift) begin
            {ofs_y_r, ofs_x_r} <=
                {ofs_y_r[OFS_W-2:0], ofs_x_r, fs0_q};
            ser_cnt_r <= ser_cnt_r + 5'h1;
        end else if (par_load) begin
            ofs_x_r <= a_d_q[OF_X +: OFS_W];
            ofs_y_r <= a_d_q[OF_Y +: OFS_W];
        end
    end

    // ---------------------------------------------------------------
    // pin outputs
    // ---------------------------------------------------------------
    assign full_or_input_ready_flag_out = ~full & prog_done & ~ptr_rst;
    assign empty_or_output_ready_flag_out = ~empty & ~ptr_rst;
    assign mailbox_one_flag_out = mailbox_one_flag_r;
    assign mailbox_two_flag_out = mailbox_two_flag_r;
    assign a_data_out = mail2_r;
    assign a_data_oe_out = ~csa_n_q & ~wra_q;
    assign b_data_out = mbb_q ? mail1_r : b_out_r;
    assign b_data_oe_out = ~csb_n_q & wrb_q;

    // ---------------------------------------------------------------
    // avalon-mm slave, one wait cycle per access
    // ---------------------------------------------------------------
    logic avs_req;
    logic [31:0] status_w;
    logic [31:0] rd_mux;

    assign avs_req = avs_read_in | avs_write_in;
    assign avs_waitrequest_out = avs_req & ~ack_r;
    assign avs_readdata_out = rdata_r;

    assign status_w = {11'h0, fill, 2'h0, prg_r, fwft, big_r, width_r,
                       mailbox_two_flag_r, mailbox_one_flag_r, empty_or_output_ready_flag_out,
                       full_or_input_ready_flag_out};
    assign rd_mux = (avs_address_in == REG_STATUS) ? status_w
                  : (avs_address_in == REG_OFFSETS)
                    ? {8'h0, ofs_y_r, 8'h0, ofs_x_r} : 32'h0;

    always_ff @(posedge clk_in or negedge rst_n_in) begin
        if (!rst_n_in) begin
            ack_r <= 1'b0;
            rdata_r <= 32'h0;
            flush_r <= 1'b0;
        end else begin
            ack_r <= avs_req & ~ack_r;
            if (avs_read_in & ~ack_r) begin
                rdata_r <= rd_mux;
            end
            flush_r <= avs_write_in & ack_r & avs_byteenable_in[0]
                     & (avs_address_in == REG_CONTROL)
                     & avs_writedata_in[CT_FLUSH];
        end
    end

endmodule

// ==== testbench/bmf_port_ctrl_sva.sv ====
// assertions on the pins of the fifo port control
// assumes it is bound onto bmf_port_ctrl and sees its ports only
`timescale 1ns/10ps
module bmf_port_ctrl_sva (
    // clock, reset and pins
    input wire logic clk_in, rst_n_in,
    input wire logic port_a_write_read_select_in,
    input wire logic port_b_chip_select_n_in, port_b_write_read_select_in,
    input wire logic full_reset_one_in, full_reset_two_in,
    input wire logic partial_reset_n_in, avs_read_in,
    // outputs
    input wire logic a_data_oe_out, b_data_oe_out, avs_waitrequest_out,
    input wire logic mailbox_one_flag_out, mailbox_two_flag_out,
    input wire logic empty_or_output_ready_flag_out
);
    default clocking @(posedge clk_in); endclocking
    default disable iff (!rst_n_in);
    chk_a_wr_float: assert property (
        port_a_write_read_select_in [*4] |-> !a_data_oe_out)
        else $error("a outputs driven while writing");
    chk_b_cs_float: assert property (
        port_b_chip_select_n_in [*4] |-> !b_data_oe_out)
        else $error("b outputs driven while deselected");
    chk_b_wr_float: assert property (
        !port_b_write_read_select_in [*4] |-> !b_data_oe_out)
        else $error("b outputs driven while writing");
    chk_b_rd_drive: assert property (
        (!port_b_chip_select_n_in && port_b_write_read_select_in) [*4]
        |-> b_data_oe_out) else $error("b outputs not driven on read");
    chk_mailbox_one_flag_reset: assert property (
        !full_reset_one_in [*4] |-> mailbox_one_flag_out)
        else $error("mail one flag low in reset");
    chk_mailbox_two_flag_reset: assert property (
        !full_reset_two_in [*4] |-> mailbox_two_flag_out)
        else $error("mail two flag low in reset");
    chk_prs_clear: assert property (
        !partial_reset_n_in [*4] |-> mailbox_one_flag_out
        && mailbox_two_flag_out && !empty_or_output_ready_flag_out)
        else $error("partial reset did not clear");
    chk_full_clear: assert property (
        (!full_reset_one_in && !full_reset_two_in) [*4]
        |-> !empty_or_output_ready_flag_out)
        else $error("full reset left data");
    cover property ($fell(mailbox_one_flag_out));
    cover property ($rose(empty_or_output_ready_flag_out));
    cover property (avs_read_in && !avs_waitrequest_out);
endmodule

bind bmf_port_ctrl bmf_port_ctrl_sva u_bmf_port_ctrl_sva (.*);

// ==== testbench/bmf_far_clocks.sv ====
// free-running port clocks of the processors on both sides
// assumes clk_in at 10 mhz; half periods counted in its cycles
`timescale 1ns/10ps
module bmf_far_clocks #(
    parameter int HALF_A = 5,
    parameter int HALF_B = 6
) (
    input wire logic clk_in,
    output logic port_a_clock_out = 1'b0,
    output logic port_b_clock_out = 1'b0
);
    int cnt_a = 0;
    int cnt_b = 0;
    // never stopped, so every 60-cycle full reset sees at least ten edges of each
    always @(posedge clk_in) begin
        cnt_a <= (cnt_a == HALF_A - 1) ? 0 : cnt_a + 1;
        cnt_b <= (cnt_b == HALF_B - 1) ? 0 : cnt_b + 1;
        if (cnt_a == HALF_A - 1)
            port_a_clock_out <= !port_a_clock_out;
        if (cnt_b == HALF_B - 1)
            port_b_clock_out <= !port_b_clock_out;
    end
endmodule

// ==== testbench/tb.sv ====
// self-checking bench for the fifo port control
// assumes the far-side clock model and the bound checker
`timescale 1ns/10ps
module tb;
    import bmf_pkg::*;
    logic clk_in = 0, rst_n_in = 0, port_a_clock_in, port_b_clock_in;
    logic port_a_enable_in = 0, port_a_chip_select_n_in = 1;
    logic port_a_write_read_select_in = 1, port_a_mailbox_select_in = 0;
    logic port_b_enable_in = 0, port_b_chip_select_n_in = 1;
    logic port_b_write_read_select_in = 1, port_b_mailbox_select_in = 0;
    logic [DATA_W-1:0] a_data_in = 0, b_data_in = 0, a_data_out, b_data_out;
    logic a_data_oe_out, b_data_oe_out, full_or_input_ready_flag_out;
    logic empty_or_output_ready_flag_out, mailbox_one_flag_out;
    logic mailbox_two_flag_out, avs_waitrequest_out, avs_read_in = 0;
    logic full_reset_one_in = 1, full_reset_two_in = 1;
    logic partial_reset_n_in = 1, serial_program_mode_n_in = 1;
    logic bus_match_select_in = 1, size_select_in = 1;
    logic byte_order_timing_select_in = 1, avs_write_in = 0;
    logic offset_select1_serial_enable_in = 1;
    logic offset_select0_serial_data_in = 0;
    logic [1:0] avs_address_in = 0;
    logic [31:0] avs_writedata_in = 0, avs_readdata_out, r;
    logic [3:0] avs_byteenable_in = 4'hf;
    int errors = 0, num_checks = 0;
    always #50 clk_in = !clk_in;
    bmf_far_clocks u_bmf_far_clocks (.clk_in(clk_in),
        .port_a_clock_out(port_a_clock_in), .port_b_clock_out(port_b_clock_in));
    bmf_port_ctrl u_bmf_port_ctrl (.*);
    task automatic chk(input string nm, input logic [35:0] e, g);
        num_checks++;
        if (g !== e) begin
            errors++;
            $display("unexpected %s: expected %h seen %h", nm, e, g);
        end
    endtask
    // wait until the chosen port clock has just fallen
    task automatic fall(input bit b);
        int n = 0;
        while (!(b ? port_b_clock_in : port_a_clock_in) && n++ < 40)
            @(posedge clk_in);
        while ((b ? port_b_clock_in : port_a_clock_in) && n++ < 40)
            @(posedge clk_in);
    endtask
    task automatic ao(input logic en, wr, mb, input logic [35:0] d);
        fall(0);
        port_a_enable_in <= en;
        port_a_write_read_select_in <= wr;
        port_a_mailbox_select_in <= mb;
        a_data_in <= d;
        fall(0);
        port_a_enable_in <= 0;
        repeat (3) @(posedge clk_in);
    endtask
    task automatic bo(input logic en, wr, mb, input logic [35:0] d);
        fall(1);
        port_b_enable_in <= en;
        port_b_write_read_select_in <= wr;
        port_b_mailbox_select_in <= mb;
        b_data_in <= d;
        fall(1);
        port_b_enable_in <= 0;
        repeat (3) @(posedge clk_in);
    endtask
    task automatic av(input logic wr, input logic [1:0] ad,
                      input logic [31:0] wd);
        int n = 0;
        avs_address_in <= ad;
        avs_writedata_in <= wd;
        avs_write_in <= wr;
        avs_read_in <= !wr;
        do @(posedge clk_in);
        while (avs_waitrequest_out !== 1'b0 && n++ < 50);
        chk("waitrequest", 0, avs_waitrequest_out);
        r = avs_readdata_out;
        avs_write_in <= 0;
        avs_read_in <= 0;
        @(posedge clk_in);
    endtask
    task automatic full_reset(input logic ser);
        serial_program_mode_n_in <= ser;
        offset_select1_serial_enable_in <= !ser;
        full_reset_one_in <= 0;
        full_reset_two_in <= 0;
        repeat (60) @(posedge clk_in);
        full_reset_one_in <= 1;
        full_reset_two_in <= 1;
        repeat (6) @(posedge clk_in);
        offset_select1_serial_enable_in <= 1;
    endtask
    task automatic t_cfg;
        full_reset(1);
        port_a_chip_select_n_in <= 0;
        port_b_chip_select_n_in <= 0;
        av(0, REG_STATUS, 0);
        chk("status", {PRG_DONE, 2'h1, BMF_W9}, r[9:4]);
        av(0, REG_OFFSETS, 0);
        chk("offsets", {8'h0, OFS_PRESET_64, 8'h0, OFS_PRESET_64}, r);
        av(1, 2'h3, 32'hffffffff);
        av(0, 2'h3, 0);
        chk("unmapped", 0, r);
        chk("full flag", 1, full_or_input_ready_flag_out);
    endtask
    task automatic t_fifo;
        logic [35:0] w = 36'h123456789;
        port_a_chip_select_n_in <= 1;
        ao(1, 1, 0, w);
        port_a_chip_select_n_in <= 0;
        ao(0, 1, 0, w);
        chk("empty flag", 0, empty_or_output_ready_flag_out);
        ao(1, 1, 0, w);
        chk("empty flag", 1, empty_or_output_ready_flag_out);
        for (int i = 0; i < 4; i++) begin
            bo(1, 1, 0, 0);
            chk("piece", (w >> (27 - 9 * i)) & 36'h1ff, b_data_out);
        end
        chk("empty flag", 0, empty_or_output_ready_flag_out);
    endtask
    task automatic t_mail;
        ao(1, 1, 1, 36'h5550a1);
        chk("mail one flag", 0, mailbox_one_flag_out);
        chk("empty flag", 0, empty_or_output_ready_flag_out);
        ao(1, 1, 1, 36'h0b2);
        bo(0, 1, 1, 0);
        chk("mail one", 36'h0a1, b_data_out);
        chk("mail one flag", 0, mailbox_one_flag_out);
        bo(1, 1, 1, 0);
        chk("mail one flag", 1, mailbox_one_flag_out);
        bo(1, 0, 1, 36'h7771c3);
        chk("mail two flag", 0, mailbox_two_flag_out);
        bo(1, 0, 1, 36'h0d4);
        ao(0, 0, 1, 0);
        chk("mail two", 36'h1c3, a_data_out);
        ao(1, 0, 1, 0);
        chk("mail two flag", 1, mailbox_two_flag_out);
        bo(0, 1, 0, 0);
    endtask
    task automatic t_prs;
        ao(1, 1, 0, 36'h9);
        ao(1, 1, 1, 36'h5);
        partial_reset_n_in <= 0;
        repeat (6) @(posedge clk_in);
        chk("empty flag", 0, empty_or_output_ready_flag_out);
        chk("mail one flag", 1, mailbox_one_flag_out);
        chk("b output", 0, b_data_out);
        partial_reset_n_in <= 1;
        repeat (4) @(posedge clk_in);
        av(0, REG_STATUS, 0);
        chk("status", {PRG_DONE, 2'h1, BMF_W9}, r[9:4]);
        ao(1, 1, 0, 36'h9);
        av(1, REG_CONTROL, 32'h1);
        repeat (4) @(posedge clk_in);
        chk("empty flag", 0, empty_or_output_ready_flag_out);
    endtask
    task automatic t_serial;
        logic [15:0] pat = 16'ha53c;
        ao(1, 1, 0, 36'h3);
        byte_order_timing_select_in <= 0;
        full_reset(0);
        chk("empty flag", 0, empty_or_output_ready_flag_out);
        chk("full flag", 0, full_or_input_ready_flag_out);
        for (int i = 15; i >= 0; i--) begin
            fall(0);
            offset_select1_serial_enable_in <= 0;
            offset_select0_serial_data_in <= pat[i];
            fall(0);
            offset_select1_serial_enable_in <= 1;
        end
        av(0, REG_OFFSETS, 0);
        chk("offsets", {8'h0, 8'ha5, 8'h0, 8'h3c}, r);
        chk("full flag", 1, full_or_input_ready_flag_out);
        ao(1, 1, 0, 36'h0a5);
        chk("ready flag", 1, empty_or_output_ready_flag_out);
        chk("fall-through", 36'h0a5, b_data_out);
    endtask
    task automatic complete_run;
        $display("checks %0d errors %0d", num_checks, errors);
        if (errors == 0 && num_checks > 0)
            $display("Test passed");
        else
            $display("Test failed");
        $finish;
    endtask
    initial begin
        repeat (4) @(posedge clk_in);
        rst_n_in <= 1;
        @(posedge clk_in);
        t_cfg;
        t_fifo;
        t_mail;
        t_prs;
        t_serial;
        complete_run;
    end
    initial begin
        repeat (10000) @(posedge clk_in);
        errors++;
        complete_run;
    end
endmodule
